// ==== hw/rpss_pin_select.sv ====
// Top of the remappable pin select slice with its Wishbone register file
//
// Local design decisions: register access over Wishbone and the register offsets.
module rpss_pin_select
    import rpss_pkg::*;
#(
    parameter int HIGHEST_INPUT_CODE = 181
)
(
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic                          wb_we_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    output logic                               wb_ack_o,
    input  wire logic [HIGHEST_INPUT_CODE:2]   inputPins,
    input  wire logic                          comparatorOne,
    input  wire logic [FUNC_COUNT-1:0]         periphFunc,
    output logic                               sent2Input,
    output logic      [SLOT_COUNT-1:0]         remapPinOut,
    output logic      [SLOT_COUNT-1:0]         remapPinOe
);

    // ********************************
    // Elaboration checks
    // ********************************
    // Codes are 8 bits wide, so sources above 255 cannot be named
    if (HIGHEST_INPUT_CODE < 2 || HIGHEST_INPUT_CODE > 255)
    begin : gCheck
        $error("HIGHEST_INPUT_CODE out of range");
    end

    // ********************************
    // Helpers
    // ********************************
    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] ofs);
        addr_hit = (adr[7:2] == ofs[7:2]);
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  sel,
                                               input logic [15:0] mask);
        logic [15:0] merged;
        merged[7:0]  = sel[0] ? wdata[7:0]  : old[7:0];
        merged[15:8] = sel[1] ? wdata[15:8] : old[15:8];
        lane_merge   = merged & mask;
    endfunction

    // ********************************
    // Bus slave and map registers
    // ********************************
    logic [15:0] sentMap;
    logic [15:0] outMap0;
    logic [15:0] outMap1;
    logic [15:0] next_sentMap;
    logic [15:0] next_outMap0;
    logic [15:0] next_outMap1;
    logic        next_ack;
    logic [31:0] next_rdData;
    logic        busReq;
    logic        busWrite;

    // One request is answered one cycle later; ack can never stand two cycles
    always_comb
    begin
        busReq       = wb_cyc_i && wb_stb_i && !wb_ack_o;
        busWrite     = busReq && wb_we_i;
        next_ack     = busReq;
        next_sentMap = sentMap;
        next_outMap0 = outMap0;
        next_outMap1 = outMap1;
        next_rdData  = 32'h0000_0000;
        if (busWrite && addr_hit(wb_adr_i, OFS_SENT_MAP))
        begin
            next_sentMap = lane_merge(sentMap, wb_dat_i, wb_sel_i, SENT_MAP_MASK); // R6
        end
        if (busWrite && addr_hit(wb_adr_i, OFS_OUT_MAP_0))
        begin
            next_outMap0 = lane_merge(outMap0, wb_dat_i, wb_sel_i, OUT_MAP_MASK); // R6
        end
        if (busWrite && addr_hit(wb_adr_i, OFS_OUT_MAP_1))
        begin
            next_outMap1 = lane_merge(outMap1, wb_dat_i, wb_sel_i, OUT_MAP_MASK); // R6
        end
        // Unmapped reads answer with zero rather than stalling the bus
        if (busReq && !wb_we_i)
        begin
            if (addr_hit(wb_adr_i, OFS_SENT_MAP))
            begin
                next_rdData = {16'h0000, sentMap & SENT_MAP_MASK}; // R6
            end
            else if (addr_hit(wb_adr_i, OFS_OUT_MAP_0))
            begin
                next_rdData = {16'h0000, outMap0 & OUT_MAP_MASK}; // R6
            end
            else if (addr_hit(wb_adr_i, OFS_OUT_MAP_1))
            begin
                next_rdData = {16'h0000, outMap1 & OUT_MAP_MASK}; // R6
            end
            else
            begin
                next_rdData = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sentMap  <= SENT_MAP_RESET; // R7
            outMap0  <= OUT_MAP_RESET; // R7
            outMap1  <= OUT_MAP_RESET; // R7
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            sentMap  <= next_sentMap;
            outMap0  <= next_outMap0;
            outMap1  <= next_outMap1;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdData;
        end
    end

    // ********************************
    // Input source selection
    // ********************************
    logic [HIGHEST_INPUT_CODE:0] srcMeta;
    logic [HIGHEST_INPUT_CODE:0] srcSync;
    logic [SENT_CODE_W-1:0]      sent2Code;
    logic                        next_sent2Input;

    assign sent2Code = sentMap[SENT_CODE_LSB +: SENT_CODE_W];

    // Pins and comparator are asynchronous; code 0 lands on a flop tied low
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            srcMeta <= '0;
            srcSync <= '0;
        end
        else
        begin
            srcMeta <= {inputPins, comparatorOne, 1'b0};
            srcSync <= srcMeta;
        end
    end

    always_comb
    begin
        next_sent2Input = 1'b0;
        if (sent2Code != SRC_GROUND && 32'(sent2Code) <= HIGHEST_INPUT_CODE)
        begin
            next_sent2Input = srcSync[sent2Code]; // R1
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sent2Input <= 1'b0;
        end
        else
        begin
            sent2Input <= next_sent2Input;
        end
    end

    // ********************************
    // Output pin slots: 0 pin 20, 1 pin 35, 2 pin 36, 3 pin 37
    // ********************************
    rpss_slot_if slotIf [SLOT_COUNT] ();

    assign slotIf[0].code = outMap0[FUNC_LO_LSB +: FUNC_CODE_W]; // R3
    assign slotIf[1].code = outMap0[FUNC_HI_LSB +: FUNC_CODE_W]; // R2
    assign slotIf[2].code = outMap1[FUNC_LO_LSB +: FUNC_CODE_W]; // R5
    assign slotIf[3].code = outMap1[FUNC_HI_LSB +: FUNC_CODE_W]; // R4

    for (genvar s = 0; s < SLOT_COUNT; s++)
    begin : gSlot
        assign slotIf[s].funcs = periphFunc;
        assign remapPinOut[s]  = slotIf[s].pinOut;
        assign remapPinOe[s]   = slotIf[s].pinDrive;
        rpss_out_slot uSlot
        (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .slotIf  (slotIf[s])
        );
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence map_write_s;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    endsequence

    bus_ack_pulse_a : assert property (bus_req_s |=> ack_pulse_s)
        else $error("Ack is not a single pulse one cycle after request");

    ack_cause_a : assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("Ack without a pending request");

    rdata_idle_a : assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("Read data shown without ack");

    reset_clear_a : assert property (disable iff (1'b0) // R7
        $past(sys_rst) && !sys_rst |-> (sentMap == 16'h0000 && outMap0 == 16'h0000
                                        && outMap1 == 16'h0000 && !sent2Input))
        else $error("Maps not cleared after reset");

    reset_pins_a : assert property (disable iff (1'b0) // R7
        $past(sys_rst) && !sys_rst |-> remapPinOe == '0 && remapPinOut == '0)
        else $error("Pins driven after reset");

    sent_write_a : assert property (bus_req_s and (wb_we_i && wb_sel_i[0] // R1
        && addr_hit(wb_adr_i, OFS_SENT_MAP)) |=> sent2Code == $past(wb_dat_i[7:0]))
        else $error("Input map write lost");

    out0_low_write_a : assert property ((map_write_s and (wb_sel_i[0] // R3
        && addr_hit(wb_adr_i, OFS_OUT_MAP_0))) |=> outMap0[5:0] == $past(wb_dat_i[5:0]))
        else $error("Pin 20 code write lost");

    out0_high_write_a : assert property ((map_write_s and (wb_sel_i[1] // R2
        && addr_hit(wb_adr_i, OFS_OUT_MAP_0))) |=> outMap0[13:8] == $past(wb_dat_i[13:8]))
        else $error("Pin 35 code write lost");

    out1_low_write_a : assert property ((map_write_s and (wb_sel_i[0] // R5
        && addr_hit(wb_adr_i, OFS_OUT_MAP_1))) |=> outMap1[5:0] == $past(wb_dat_i[5:0]))
        else $error("Pin 36 code write lost");

    out1_high_write_a : assert property ((map_write_s and (wb_sel_i[1] // R4
        && addr_hit(wb_adr_i, OFS_OUT_MAP_1))) |=> outMap1[13:8] == $past(wb_dat_i[13:8]))
        else $error("Pin 37 code write lost");

    reserved_hold_a : assert property ((sentMap & ~SENT_MAP_MASK) == 16'h0000 // R6
        && (outMap0 & ~OUT_MAP_MASK) == 16'h0000 && (outMap1 & ~OUT_MAP_MASK) == 16'h0000)
        else $error("Unimplemented map bits set");

    map_hold_a : assert property (!(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o)
        |=> $stable(sentMap) && $stable(outMap0) && $stable(outMap1))
        else $error("Map changed without a write");

    reserved_read_a : assert property (wb_ack_o && !$past(wb_we_i) // R6
        |-> wb_dat_o[31:14] == 18'h0_0000 && wb_dat_o[7:6] == 2'b00
            || addr_hit($past(wb_adr_i), OFS_SENT_MAP) && wb_dat_o[31:8] == 24'h00_0000)
        else $error("Unimplemented bits read nonzero");

    ground_src_a : assert property (sent2Code == SRC_GROUND |=> !sent2Input) // R1
        else $error("Grounded input not low");

    sent_range_a : assert property (32'(sent2Code) > HIGHEST_INPUT_CODE |=> !sent2Input) // R1
        else $error("Out of range source code not low");

    comparator_path_a : assert property ((sent2Code == SRC_COMPARATOR) [*4] // R1
        |-> sent2Input == $past(comparatorOne, 3))
        else $error("Comparator not routed to SENT input");

    top_pin_path_a : assert property ((sent2Code == SRC_HIGHEST_PIN) [*4] // R1
        |-> sent2Input == $past(inputPins[HIGHEST_INPUT_CODE], 3))
        else $error("Highest input pin not routed to SENT input");

    pin20_drive_on_a : assert property (slotIf[0].code != FUNC_NONE |=> remapPinOe[0]) // R3
        else $error("Pin 20 not driven for nonzero code");

    pin35_idle_a : assert property (slotIf[1].code == FUNC_NONE // R2
        |=> !remapPinOe[1] && !remapPinOut[1])
        else $error("Pin 35 driven with code zero");

    pin36_idle_a : assert property (slotIf[2].code == FUNC_NONE // R5
        |=> !remapPinOe[2] && !remapPinOut[2])
        else $error("Pin 36 driven with code zero");

    pin37_idle_a : assert property (slotIf[3].code == FUNC_NONE // R4
        |=> !remapPinOe[3] && !remapPinOut[3])
        else $error("Pin 37 driven with code zero");

    pin20_data_a : assert property (slotIf[0].code != FUNC_NONE // R3
        |=> remapPinOut[0] == $past(periphFunc[slotIf[0].code]))
        else $error("Pin 20 does not carry its function");

    pin35_data_a : assert property (slotIf[1].code != FUNC_NONE // R2
        |=> remapPinOut[1] == $past(periphFunc[slotIf[1].code]))
        else $error("Pin 35 does not carry its function");

    pin36_data_a : assert property (slotIf[2].code != FUNC_NONE // R5
        |=> remapPinOut[2] == $past(periphFunc[slotIf[2].code]))
        else $error("Pin 36 does not carry its function");

    pin37_data_a : assert property (slotIf[3].code != FUNC_NONE // R4
        |=> remapPinOut[3] == $past(periphFunc[slotIf[3].code]))
        else $error("Pin 37 does not carry its function");

    pin35_drive_a : assert property (outMap0[13:8] != 6'h00 |=> remapPinOe[1]) // R2
        else $error("Pin 35 not driven for nonzero code");

    pin20_drive_a : assert property (outMap0[5:0] == 6'h00 |=> !remapPinOe[0]) // R3
        else $error("Pin 20 driven with code zero");

    pin37_drive_a : assert property (outMap1[13:8] != 6'h00 |=> remapPinOe[3]) // R4
        else $error("Pin 37 not driven for nonzero code");

    pin36_drive_a : assert property (outMap1[5:0] != 6'h00 |=> remapPinOe[2]) // R5
        else $error("Pin 36 not driven for nonzero code");
endmodule

// ==== hw/rpss_pkg.sv ====
// Package of register map, field layout and source codes for the pin select slice
// Notes on behaviour
// (R1) The second SENT input follows the source named by an 8-bit code: 181 is the highest input pin, 1 is comparator one, 0 is ground.
// (R2) Bits 13 to 8 of the first output map select the function driving remappable pin 35.
// (R3) Bits 5 to 0 of the first output map select the function driving remappable pin 20.
// (R4) Bits 13 to 8 of the second output map select the function driving remappable pin 37.
// (R5) Bits 5 to 0 of the second output map select the function driving remappable pin 36.
// (R6) Unimplemented bits read as zero and ignore writes in all three maps.
// (R7) Every selector field clears to zero on reset, grounding the input and zeroing each output code.
package rpss_pkg;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [7:0]  OFS_SENT_MAP       = 8'h00;
    localparam logic [7:0]  OFS_OUT_MAP_0      = 8'h04;
    localparam logic [7:0]  OFS_OUT_MAP_1      = 8'h08;

    // ********************************
    // Field layout and reset values
    // ********************************
    localparam int          SENT_CODE_W        = 8;
    localparam int          SENT_CODE_LSB      = 0;
    localparam int          FUNC_CODE_W        = 6;
    localparam int          FUNC_HI_LSB        = 8;
    localparam int          FUNC_LO_LSB        = 0;
    localparam int          FUNC_COUNT         = 64;
    localparam int          SLOT_COUNT         = 4;
    localparam logic [15:0] SENT_MAP_MASK      = 16'h00ff;
    localparam logic [15:0] OUT_MAP_MASK       = 16'h3f3f;
    localparam logic [15:0] SENT_MAP_RESET     = 16'h0000;
    localparam logic [15:0] OUT_MAP_RESET      = 16'h0000;

    // ********************************
    // Source and function codes
    // ********************************
    localparam logic [7:0]  SRC_GROUND         = 8'h00;
    localparam logic [7:0]  SRC_COMPARATOR     = 8'h01;
    localparam logic [7:0]  SRC_HIGHEST_PIN    = 8'hb5;
    localparam logic [5:0]  FUNC_NONE          = 6'h00;

endpackage

// ==== hw/rpss_slot_if.sv ====
// Interface between the register block and one output pin slot
interface rpss_slot_if;
    import rpss_pkg::*;
    logic [FUNC_CODE_W-1:0] code;
    logic [FUNC_COUNT-1:0]  funcs;
    logic                   pinOut;
    logic                   pinDrive;

    modport slot
    (
        input  code,
        input  funcs,
        output pinOut,
        output pinDrive
    );

    modport owner
    (
        output code,
        output funcs,
        input  pinOut,
        input  pinDrive
    );
endinterface

// ==== hw/rpss_out_slot.sv ====
// One remappable output pin: function select and output register
module rpss_out_slot
    import rpss_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    rpss_slot_if.slot slotIf
);

    logic pinOut;
    logic pinDrive;
    logic next_pinOut;
    logic next_pinDrive;
    logic selFunc;

    // Code zero leaves the pin undriven by any peripheral
    always_comb
    begin
        selFunc       = slotIf.funcs[slotIf.code];
        next_pinOut   = (slotIf.code == FUNC_NONE) ? 1'b0 : selFunc;
        next_pinDrive = (slotIf.code != FUNC_NONE);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pinOut   <= 1'b0;
            pinDrive <= 1'b0;
        end
        else
        begin
            pinOut   <= next_pinOut;
            pinDrive <= next_pinDrive;
        end
    end

    assign slotIf.pinOut   = pinOut;
    assign slotIf.pinDrive = pinDrive;

    slot_follow_a : assert property (@(posedge ref_clk) disable iff (sys_rst) // R2 R3 R4 R5
        (slotIf.code != FUNC_NONE) |=> (pinOut == $past(selFunc)))
        else $error("Pin output does not follow selected function");
endmodule

// ==== verif/rpss_far_model.sv ====
// Model of the pads and peripherals facing the pin select slice
module rpss_far_model
    import rpss_pkg::*;
#(
    parameter int HIGHEST_INPUT_CODE = 181
)
(
    input  wire logic [FUNC_CODE_W-1:0]      funcSel,
    input  wire logic                        cmpLevel,
    input  wire logic                        pinLevel,
    output logic      [HIGHEST_INPUT_CODE:2] inputPins,
    output logic                             comparatorOne,
    output logic      [FUNC_COUNT-1:0]       periphFunc
);
    timeunit 1ns;
    timeprecision 1ns;

    always_comb
    begin
        // Other pins show the opposite level so a wrong pick is seen
        inputPins = {(HIGHEST_INPUT_CODE - 1){~pinLevel}};
        inputPins[HIGHEST_INPUT_CODE] = pinLevel;
        comparatorOne = cmpLevel;
        // One peripheral function active at a time
        periphFunc = '0;
        periphFunc[funcSel] = 1'b1;
    end
endmodule

// ==== verif/tb_top.sv ====
// Register and pin path testbench for the pin select slice
module tb_top
    import rpss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 ref_clk;
    logic                 sys_rst;
    logic [7:0]           wb_adr_i;
    logic [31:0]          wb_dat_i;
    logic [31:0]          wb_dat_o;
    logic [3:0]           wb_sel_i;
    logic                 wb_we_i;
    logic                 wb_cyc_i;
    logic                 wb_stb_i;
    logic                 wb_ack_o;
    logic [181:2]         inputPins;
    logic                 comparatorOne;
    logic [FUNC_COUNT-1:0] periphFunc;
    logic                 sent2Input;
    logic [3:0]           remapPinOut;
    logic [3:0]           remapPinOe;
    logic [5:0]           funcSel;
    logic                 cmpLevel;
    logic                 pinLevel;
    int                   error_cnt;
    int                   n_checks;
    logic [5:0]           fCode [5] = '{6'h05, 6'h0c, 6'h21, 6'h3f, 6'h07};
    logic [3:0]           fExp [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    logic [7:0]           sCode [6] = '{8'h01, 8'h01, 8'hb5, 8'hb5, 8'h00, 8'hb6};
    logic [2:0]           sLvl [6] = '{3'b101, 3'b010, 3'b011, 3'b100, 3'b110, 3'b110};
    logic [7:0]           ofs [3] = '{OFS_SENT_MAP, OFS_OUT_MAP_0, OFS_OUT_MAP_1};

    rpss_pin_select #(.HIGHEST_INPUT_CODE(181)) i_rpss_pin_select
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .inputPins(inputPins),
        .comparatorOne(comparatorOne), .periphFunc(periphFunc), .sent2Input(sent2Input),
        .remapPinOut(remapPinOut), .remapPinOe(remapPinOe)
    );

    rpss_far_model #(.HIGHEST_INPUT_CODE(181)) i_rpss_far_model
    (
        .funcSel(funcSel), .cmpLevel(cmpLevel), .pinLevel(pinLevel),
        .inputPins(inputPins), .comparatorOne(comparatorOne), .periphFunc(periphFunc)
    );

    // ********************************
    // Clock and bus tasks
    // ********************************
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // Request held until ack is sampled high at a rising edge
    task automatic wbXfer(input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel, input logic we, output logic [31:0] rd);
        @(posedge ref_clk);
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        wb_we_i <= we;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wbWrite(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] unused;
        wbXfer(adr, dat, sel, 1'b1, unused);
    endtask

    task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic checkPin(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: pins %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic readCheck(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wbXfer(adr, 32'h0000_0000, 4'hf, 1'b0, rd);
        checkData(rd, exp);
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ********************************
    // Tests
    // ********************************
    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
        {funcSel, cmpLevel, pinLevel} = '0;
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        checkPin(remapPinOe | remapPinOut | {3'b000, sent2Input}, 4'h0);
        for (int i = 0; i < 3; i++) readCheck(ofs[i], 32'h0000_0000);
        wbWrite(OFS_SENT_MAP, 32'hffff_ffff, 4'hf);
        readCheck(OFS_SENT_MAP, 32'h0000_00ff);
        wbWrite(OFS_OUT_MAP_0, 32'hffff_ffff, 4'hf);
        readCheck(OFS_OUT_MAP_0, 32'h0000_3f3f);
        wbWrite(OFS_OUT_MAP_1, 32'hffff_ffff, 4'hf);
        readCheck(OFS_OUT_MAP_1, 32'h0000_3f3f);
        wbWrite(8'h0c, 32'hffff_ffff, 4'hf);
        readCheck(8'h0c, 32'h0000_0000);
        // Upper byte alone cleared; lower byte must survive
        wbWrite(OFS_OUT_MAP_0, 32'h0000_0000, 4'h2);
        readCheck(OFS_OUT_MAP_0, 32'h0000_003f);
        wbWrite(OFS_OUT_MAP_0, 32'h0000_0c05, 4'h3);
        wbWrite(OFS_OUT_MAP_1, 32'h0000_3f21, 4'h3);
        readCheck(OFS_OUT_MAP_0, 32'h0000_0c05);
        readCheck(OFS_OUT_MAP_1, 32'h0000_3f21);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge ref_clk);
            funcSel <= fCode[k];
            repeat (3) @(negedge ref_clk);
            checkPin(remapPinOut, fExp[k]);
            checkPin(remapPinOe, 4'hf);
        end
        wbWrite(OFS_OUT_MAP_0, 32'h0000_0000, 4'h3);
        repeat (3) @(negedge ref_clk);
        checkPin(remapPinOe, 4'hc);
        for (int s = 0; s < 6; s++)
        begin
            wbWrite(OFS_SENT_MAP, {24'h00_0000, sCode[s]}, 4'h1);
            @(posedge ref_clk);
            cmpLevel <= sLvl[s][2];
            pinLevel <= sLvl[s][1];
            repeat (5) @(negedge ref_clk);
            checkPin({3'b000, sent2Input}, {3'b000, sLvl[s][0]});
        end
        // Second reset in mid-run with the input map and second output map nonzero
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        checkPin(remapPinOe | remapPinOut | {3'b000, sent2Input}, 4'h0);
        for (int i = 0; i < 3; i++) readCheck(ofs[i], 32'h0000_0000);
        summarize();
    end

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        summarize();
    end
endmodule
